// >>> unf_pkg.sv
// Package of constants and types for the receive-line noise filter.
package unf_pkg;

  // ==========================================================================
  // Noise rejection selector codes
  localparam logic [1:0] REJ_NONE = 2'h0;
  localparam logic [1:0] REJ_31   = 2'h1;
  localparam logic [1:0] REJ_63   = 2'h2;
  localparam logic [1:0] REJ_127  = 2'h3;

  // ==========================================================================
  // Glitch width thresholds in high-frequency clock periods
  localparam int         CNT_W   = 7;
  localparam logic [6:0] THR_31  = 7'h1F;
  localparam logic [6:0] THR_63  = 7'h3F;
  localparam logic [6:0] THR_127 = 7'h7F;

  // ==========================================================================
  // Transfer clock selector codes and fixed divisions
  localparam logic [2:0] XCLK_DIV13 = 3'h0;
  localparam logic [2:0] XCLK_TIMER = 3'h6;
  localparam logic [3:0] DIV13_LAST = 4'hC;
  localparam logic [15:0] DIV_8     = 16'h0008;
  localparam logic [15:0] DIV_16    = 16'h0010;
  localparam logic [15:0] DIV_32    = 16'h0020;

  // ==========================================================================
  // Reset values
  localparam logic RX_IDLE = 1'b1;

  // ==========================================================================
  // Configuration carried as one group
  typedef struct packed {
    logic [1:0] rx_noise_reject_sel;
    logic [2:0] transfer_clock_sel;
    logic [7:0] timer_compare_value;
    logic [2:0] timer_src_shift;
  } unf_cfg_s;

  // Filter states
  typedef enum logic [1:0] {
    FLT_STABLE  = 2'b01,
    FLT_QUALIFY = 2'b10
  } unf_state_e;

endpackage

// >>> unf_xfer_clk.sv
// Transfer clock tick generator: fixed divide by 13 or timer compare divide.
`timescale 1ns/100ps
module unf_xfer_clk (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  // Configuration
  input  wire logic [2:0]      transfer_clock_sel,
  input  wire logic [7:0]      timer_compare_value,
  input  wire logic            timer_src_tick,
  // Tick out
  output logic                 xfer_tick
);

  // ==========================================================================
  // Dividers
  logic [3:0] div13_cnt;
  logic [3:0] next_div13_cnt;
  logic [7:0] tmr_cnt;
  logic [7:0] next_tmr_cnt;
  logic       next_xfer_tick;

  // A compare value of zero wraps to a full count of 256 source ticks.
  always_comb begin
    next_div13_cnt = div13_cnt;
    next_tmr_cnt   = tmr_cnt;
    next_xfer_tick = 1'b0;
    if (transfer_clock_sel == unf_pkg::XCLK_DIV13) begin
      if (div13_cnt == unf_pkg::DIV13_LAST) begin
        next_div13_cnt = 4'h0;
        next_xfer_tick = 1'b1;
      end else begin
        next_div13_cnt = div13_cnt + 4'h1;
      end
    end else begin
      next_div13_cnt = 4'h0;
    end
    if (transfer_clock_sel == unf_pkg::XCLK_TIMER) begin
      if (timer_src_tick) begin
        if (tmr_cnt == timer_compare_value - 8'h01) begin
          next_tmr_cnt   = 8'h00;
          next_xfer_tick = 1'b1;
        end else begin
          next_tmr_cnt = tmr_cnt + 8'h01;
        end
      end
    end else begin
      next_tmr_cnt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div13_cnt <= 4'h0;
      tmr_cnt   <= 8'h00;
      xfer_tick <= 1'b0;
    end else begin
      div13_cnt <= next_div13_cnt;
      tmr_cnt   <= next_tmr_cnt;
      xfer_tick <= next_xfer_tick;
    end
  end

endmodule

// >>> unf_rx_noise_filter.sv
// Receive-line noise rejection stage with transfer clock and setting check.
//
// Behaviour
// - Selector 00 passes every receive-line level change straight through, unfiltered.
// - Selector 01 ignores any receive-line pulse narrower than 31 high-frequency clock periods.
// - Selector 10 ignores any receive-line pulse narrower than 63 high-frequency clock periods.
// - Selector 11 ignores any receive-line pulse narrower than 127 high-frequency clock periods.
// - The timer-derived transfer clock is the timer source clock divided by the compare value.
`timescale 1ns/100ps
module unf_rx_noise_filter (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Receive pin from the external transmitter
  input  wire logic                 rxd_pin,
  // Configuration from the serial unit
  input  wire unf_pkg::unf_cfg_s    cfg,
  input  wire logic                 timer_src_tick,
  // Results
  output logic                      rx_filtered,
  output logic                      xfer_tick,
  output logic                      cfg_illegal
);

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] reject_threshold(input logic [1:0] sel);
    logic [6:0] thr;
    thr = unf_pkg::THR_127;
    case (sel)
      unf_pkg::REJ_31: thr = unf_pkg::THR_31;
      unf_pkg::REJ_63: thr = unf_pkg::THR_63;
      default:         thr = unf_pkg::THR_127;
    endcase
    return thr;
  endfunction

  function automatic logic setting_forbidden(input unf_pkg::unf_cfg_s c);
    logic [15:0] div;
    logic        bad;
    div = 16'({8'h00, c.timer_compare_value} << c.timer_src_shift);
    bad = 1'b0;
    if (c.transfer_clock_sel == unf_pkg::XCLK_DIV13) begin
      bad = (c.rx_noise_reject_sel == unf_pkg::REJ_127);
    end else if (c.transfer_clock_sel == unf_pkg::XCLK_TIMER) begin
      if (div == unf_pkg::DIV_8) begin
        bad = (c.rx_noise_reject_sel != unf_pkg::REJ_NONE);
      end else if (div == unf_pkg::DIV_16) begin
        bad = (c.rx_noise_reject_sel > unf_pkg::REJ_31);
      end else if (div == unf_pkg::DIV_32) begin
        bad = (c.rx_noise_reject_sel == unf_pkg::REJ_127);
      end
    end
    return bad;
  endfunction

  // ==========================================================================
  // Pin synchroniser: only the second stage is read by logic.
  logic rx_meta;
  logic rx_sync;
  logic next_rx_meta;
  logic next_rx_sync;

  always_comb begin
    next_rx_meta = rxd_pin;
    next_rx_sync = rx_meta;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_meta <= unf_pkg::RX_IDLE;
      rx_sync <= unf_pkg::RX_IDLE;
    end else begin
      rx_meta <= next_rx_meta;
      rx_sync <= next_rx_sync;
    end
  end

  // ==========================================================================
  // Glitch filter
  unf_pkg::unf_state_e state;
  unf_pkg::unf_state_e next_state;
  logic [unf_pkg::CNT_W-1:0] stable_cnt;
  logic [unf_pkg::CNT_W-1:0] next_stable_cnt;
  logic [6:0] thr;
  logic       next_rx_filtered;

  // A selector change mid-qualification takes effect on the running count,
  // which keeps the logic small at the cost of one odd-width pulse window.
  always_comb begin
    thr              = reject_threshold(cfg.rx_noise_reject_sel);
    next_state       = state;
    next_stable_cnt  = stable_cnt;
    next_rx_filtered = rx_filtered;
    if (cfg.rx_noise_reject_sel == unf_pkg::REJ_NONE) begin
      next_rx_filtered = rx_sync;
      next_state       = unf_pkg::FLT_STABLE;
      next_stable_cnt  = '0;
    end else begin
      case (state)
        unf_pkg::FLT_STABLE: begin
          if (rx_sync != rx_filtered) begin
            next_state      = unf_pkg::FLT_QUALIFY;
            next_stable_cnt = 7'h01;
          end
        end
        unf_pkg::FLT_QUALIFY: begin
          if (rx_sync == rx_filtered) begin
            next_state      = unf_pkg::FLT_STABLE;
            next_stable_cnt = '0;
          end else if (stable_cnt >= thr) begin
            next_rx_filtered = rx_sync;
            next_state       = unf_pkg::FLT_STABLE;
            next_stable_cnt  = '0;
          end else begin
            next_stable_cnt = stable_cnt + 7'h01;
          end
        end
        default: begin
          next_state      = unf_pkg::FLT_STABLE;
          next_stable_cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state       <= unf_pkg::FLT_STABLE;
      stable_cnt  <= '0;
      rx_filtered <= unf_pkg::RX_IDLE;
    end else begin
      state       <= next_state;
      stable_cnt  <= next_stable_cnt;
      rx_filtered <= next_rx_filtered;
    end
  end

  // ==========================================================================
  // Setting check, registered so the flag is glitch free.
  logic next_cfg_illegal;

  always_comb begin
    next_cfg_illegal = setting_forbidden(cfg);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_illegal <= 1'b0;
    end else begin
      cfg_illegal <= next_cfg_illegal;
    end
  end

  // ==========================================================================
  // Transfer clock
  unf_xfer_clk u_xfer_clk (
    .clk_sys             (clk_sys),
    .rstn                (rstn),
    .transfer_clock_sel  (cfg.transfer_clock_sel),
    .timer_compare_value (cfg.timer_compare_value),
    .timer_src_tick      (timer_src_tick),
    .xfer_tick           (xfer_tick)
  );

endmodule

// >>> unf_props.sv
// Assertion checker for the receive-line noise filter.
`timescale 1ns/100ps
module unf_props (
  // Clock, reset and inputs
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              rxd_pin,
  input wire unf_pkg::unf_cfg_s cfg,
  input wire logic              timer_src_tick,
  // Outputs watched
  input wire logic              rx_filtered,
  input wire logic              xfer_tick,
  input wire logic              cfg_illegal
);
  logic       pin_q;
  logic [6:0] prun;
  logic [6:0] next_prun;
  logic [8:0] tcnt;
  logic [8:0] next_tcnt;
  // ==========================================================================
  // Pin run length and timer ticks since the last transfer tick.
  always_comb begin
    next_prun = (rxd_pin != pin_q) ? 7'h00 : prun + 7'(prun != 7'h7F);
    next_tcnt = (cfg.transfer_clock_sel != 3'h6 || xfer_tick) ? 9'h000 : tcnt;
    next_tcnt = next_tcnt + 9'(timer_src_tick);
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b1;
      prun  <= 7'h00;
      tcnt  <= 9'h000;
    end else begin
      pin_q <= rxd_pin;
      prun  <= next_prun;
      tcnt  <= next_tcnt;
    end
  end
  // ==========================================================================
  // Properties.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_quiet;
    !xfer_tick [*8] ##1 !xfer_tick [*4];
  endsequence
  // The pin run is taken two samples back: the synchroniser delay plus the cycle that registers the decision, less the run counter's own register.
  property p_rej(logic [1:0] s, int n);
    $changed(rx_filtered) && cfg.rx_noise_reject_sel == s |-> $past(prun, 2) >= n;
  endproperty
  AST_PASS: assert property (
    (cfg.rx_noise_reject_sel == 2'h0) [*3] |-> rx_filtered == $past(rxd_pin, 3)) else $error("unfiltered path wrong");
  AST_REJ31: assert property (p_rej(2'h1, 31)) else $error("short pulse passed at 31");
  AST_REJ63: assert property (p_rej(2'h2, 63)) else $error("short pulse passed at 63");
  AST_REJ127: assert property (p_rej(2'h3, 127)) else $error("short pulse passed at 127");
  AST_SETTLE: assert property (
    cfg.rx_noise_reject_sel == 2'h1 && prun == 7'h24 |-> rx_filtered == $past(rxd_pin)) else $error("stable level not taken");
  AST_RESET: assert property (disable iff (1'b0)
    !rstn |=> rx_filtered && !xfer_tick && !cfg_illegal) else $error("reset levels wrong");
  AST_DIV13: assert property (
    xfer_tick && cfg.transfer_clock_sel == 3'h0 |=> s_quiet) else $error("divide by 13 tick early");
  AST_TIMER: assert property (
    xfer_tick && cfg.transfer_clock_sel == 3'h6 && $past(cfg.transfer_clock_sel) == 3'h6
    |-> tcnt == ((cfg.timer_compare_value == 8'h00) ? 9'h100 : {1'b0, cfg.timer_compare_value}))
    else $error("timer tick count wrong");
endmodule
bind unf_rx_noise_filter unf_props i_unf_props (.clk_sys, .rstn, .rxd_pin, .cfg, .timer_src_tick,
  .rx_filtered, .xfer_tick, .cfg_illegal);

// >>> unf_tx_model.sv
// Behavioural external transmitter that drives the receive line.
`timescale 1ns/100ps
module unf_tx_model (
  // Clock and line
  input  wire logic clk_sys,
  output logic      rxd
);
  initial rxd = 1'b1;
  // ==========================================================================
  // One pulse of the given level and width, then back to idle high.
  task automatic pulse(input logic lvl, input int n);
    @(negedge clk_sys);
    rxd = lvl;
    repeat (n) @(negedge clk_sys);
    rxd = 1'b1;
  endtask
endmodule

// >>> uart_rx_noise_filter_tb.sv
// Self-checking testbench for the receive-line noise filter.
`timescale 1ns/100ps
module uart_rx_noise_filter_tb;
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic              timer_src_tick = 1'b0;
  logic              rxd_pin, rx_filtered, xfer_tick, cfg_illegal, ill;
  logic              last = 1'b1;
  unf_pkg::unf_cfg_s cfg = '0;
  int                failures = 0, total_checks = 0, ticks = 0;
  logic [31:0]       seed = 32'hFAD234D9;
  logic              q[$];
  initial forever #25 clk_sys = ~clk_sys;
  unf_rx_noise_filter i_unf_rx_noise_filter (.clk_sys, .rstn, .rxd_pin, .cfg, .timer_src_tick,
    .rx_filtered, .xfer_tick, .cfg_illegal);
  unf_tx_model i_unf_tx_model (.clk_sys, .rxd(rxd_pin));
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Monitor: each filtered level change takes the oldest note; an unnoted change fails.
  always @(negedge clk_sys) begin
    ticks <= ticks + int'(xfer_tick);
    if (rstn && rx_filtered !== last) begin
      last <= rx_filtered;
      if (q.size() == 0) check(rx_filtered, last);
      else check(rx_filtered, q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    conclude();
  end
  // ==========================================================================
  // Stimulus.
  initial begin
    int n, w, t0, d;
    repeat (20) @(negedge clk_sys);
    check(rx_filtered, 1'b1);
    rstn = 1'b1;
    // Widths at the threshold, one above, and one random per selector.
    for (int s = 0; s < 4; s++) begin
      cfg.rx_noise_reject_sel = s[1:0];
      n = (s == 0) ? 0 : (32 << (s - 1)) - 1;
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        w = (k == 2) ? 1 + int'(seed % (2 * n + 2)) : n + k + int'(n == 0);
        if (w > n) begin
          q.push_back(1'b0);
          q.push_back(1'b1);
        end
        i_unf_tx_model.pulse(1'b0, w);
        repeat (2 * n + 10) @(negedge clk_sys);
      end
      $display("reject setting %0d done", s);
    end
    // Every selector against restricted and free transfer clocks.
    for (int k = 0; k < 5; k++) begin
      for (int r = 0; r < 4; r++) begin
        d = 4 << k;
        cfg.rx_noise_reject_sel = r[1:0];
        cfg.transfer_clock_sel = (k == 0) ? 3'h0 : (k == 4) ? 3'h2 : 3'h6;
        cfg.timer_compare_value = 8'(d >> (k % 2));
        cfg.timer_src_shift = 3'(k % 2);
        ill = (k == 0 && r == 3) || (k inside {[1:3]} && ((d == 8 && r != 0) || (d == 16 && r > 1) || r == 3));
        repeat (2) @(negedge clk_sys);
        check(cfg_illegal, ill);
      end
    end
    $display("setting check done");
    cfg.transfer_clock_sel = 3'h0;
    t0 = ticks;
    repeat (140) @(negedge clk_sys);
    check(ticks - t0 == 10, 1'b1);
    // Timer source ticks every second cycle; a compare of 3 gives one tick per three.
    cfg.transfer_clock_sel = 3'h6;
    cfg.timer_compare_value = 8'h03;
    t0 = ticks;
    repeat (30) begin
      timer_src_tick = 1'b1;
      @(negedge clk_sys);
      timer_src_tick = 1'b0;
      @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    check(ticks - t0 == 10, 1'b1);
    check(q.size() == 0, 1'b1);
    $display("transfer clock done");
    conclude();
  end
endmodule
